// ---- rtl/rps_pkg.sv ----
// Shared constants and types for the root port suspend and resume block
package rps_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] PORT_STATUS_OFS = 4'h0;
    localparam logic [3:0] PORT_STATE_OFS = 4'h4;

    // ==========================================================
    // Port status fields
    localparam int SUSPEND_BIT = 7;
    localparam int RESUME_DRIVE_BIT = 6;
    localparam int OC_CHANGE_BIT = 5;
    localparam int OC_ACTIVE_BIT = 4;
    localparam int PORT_ENABLED_BIT = 2;
    localparam int PORT_RESET_BIT = 8;
    localparam int PORT_POWER_BIT = 12;

    // ==========================================================
    // Reset values
    localparam logic RESUME_DRIVE_RST = 1'h0;
    localparam logic OC_CHANGE_RST = 1'h0;
    localparam logic SUSPEND_RST = 1'h0;
    localparam logic [2:0] SYNC_RST = 3'h0;

    // ==========================================================
    // Timing
    localparam int CLOCK_HZ = 125000000;
    localparam int HS_RETURN_MAX_MS = 2;
    localparam int HS_RETURN_MAX_CYC = HS_RETURN_MAX_MS * (CLOCK_HZ / 1000);
    localparam int RET_CNT_W = 18;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PS_DISABLED,
        PS_ENABLED,
        PS_SUSPENDED
    } rps_port_state_e;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_DRIVE,
        RS_RETURN
    } rps_resume_e;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } rps_av_req_s;

endpackage : rps_pkg

// ---- rtl/rps_root_port.sv ----
// Suspend, resume and over-current change logic of one root hub port
// ==========================================================
// What this block does
// - While suspended, block downstream data; only port reset signalling passes.
// - Suspend request waits for any in-progress transaction to finish.
// - While suspended, keep watching the bus for downstream resume.
// - Suspend flag reads one only once the port is actually suspended.
// - Software writes of zero to the suspend flag are ignored.
// - Software clearing the resume drive flag clears suspend.
// - Port reset rising from zero to one clears suspend.
// - Suspend and resume drive flags read zero while port power is off.
// - Software writing one to resume drive starts resume signalling.
// - J-to-K while suspended sets resume drive and port change detect.
// - Software-set resume drive leaves port change detect alone.
// - Drive full-speed K until software writes zero to resume drive.
// - Clearing resume drive returns to high-speed idle; flag holds one meanwhile.
// - Return to high-speed idle completes within 2 ms.
// - Over-current change sets on any change of over-current active.
// - Writing one clears over-current change; zero leaves it.
// - Resume drive and over-current change reset to zero.
// - Over-current active follows the over-current condition both ways.
// - Port state decodes from enabled and suspend flags.
module rps_root_port
    import rps_pkg::*;
#(
    parameter int RET_LIMIT_CYC = HS_RETURN_MAX_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic PORT_ENABLED,
    input wire logic PORT_RESET,
    input wire logic PORT_POWER,
    input wire logic XFER_BUSY,
    input wire logic HS_IDLE_DONE,
    input wire logic LINE_K,
    input wire logic OVERCURRENT_IN,
    output logic BLOCK_DOWNSTREAM,
    output logic DRIVE_RESUME_K,
    output logic DRIVE_HS_IDLE,
    output logic PORT_CHANGE_SET
);

    // ==========================================================
    // Pin synchronisers
    logic k_level;
    logic k_changed;
    logic oc_act;
    logic oc_changed;
    logic port_reset_ctl_prev_q, port_reset_ctl_prev_d;

    // Each pin gets its own filter; the line idles at J after reset
    rps_pin_sync line_k_sync_i (
        .clock(CLOCK),
        .rst_n(RST_N),
        .pin(LINE_K),
        .level(k_level),
        .changed(k_changed)
    );

    rps_pin_sync oc_sync_i (
        .clock(CLOCK),
        .rst_n(RST_N),
        .pin(OVERCURRENT_IN),
        .level(oc_act),
        .changed(oc_changed)
    );

    // Only the rising edge of port reset clears suspend, a held reset does not
    always_comb begin
        port_reset_ctl_prev_d = PORT_RESET;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            port_reset_ctl_prev_q <= 1'b0;
        end else begin
            port_reset_ctl_prev_q <= port_reset_ctl_prev_d;
        end
    end

    // ==========================================================
    // Avalon slave: one wait cycle, then the request completes
    rps_av_req_s req;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire;
    logic wr_status;
    rps_port_state_e port_state;

    assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                   writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};
    assign wr_fire = req.write && !wait_q;
    assign wr_status = wr_fire && (req.address == PORT_STATUS_OFS) && req.byteenable[0];

    // ==========================================================
    // Suspend and resume state
    rps_resume_e res_q, res_d;
    logic susp_q, susp_d;
    logic pend_q, pend_d;
    logic occ_q, occ_d;
    logic pcd_q, pcd_d;
    logic drive_k_q, drive_k_d;
    logic hs_idle_q, hs_idle_d;
    logic [RET_CNT_W-1:0] ret_cnt_q, ret_cnt_d;
    logic res_flag;
    logic j_to_k;

    assign res_flag = (res_q != RS_IDLE);
    assign j_to_k = k_changed && !k_level && susp_q;

    always_comb begin
        if (!PORT_ENABLED) begin
            port_state = PS_DISABLED;
        end else if (susp_q) begin
            port_state = PS_SUSPENDED;
        end else begin
            port_state = PS_ENABLED;
        end
    end

    always_comb begin
        res_d = res_q;
        susp_d = susp_q;
        pend_d = pend_q;
        pcd_d = 1'b0;
        ret_cnt_d = ret_cnt_q;
        occ_d = occ_q;
        if (wr_status && req.writedata[OC_CHANGE_BIT]) begin
            occ_d = 1'b0;
        end
        if (oc_changed) begin
            occ_d = 1'b1;
        end
        if (wr_status && req.writedata[SUSPEND_BIT] && !susp_q) begin
            pend_d = 1'b1;
        end
        if (pend_q && !XFER_BUSY) begin
            pend_d = 1'b0;
            susp_d = 1'b1;
        end
        case (res_q)
            RS_IDLE: begin
                if (wr_status && req.writedata[RESUME_DRIVE_BIT]) begin
                    res_d = RS_DRIVE;
                end else if (j_to_k) begin
                    res_d = RS_DRIVE;
                    pcd_d = 1'b1;
                end
            end
            RS_DRIVE: begin
                if (wr_status && !req.writedata[RESUME_DRIVE_BIT]) begin
                    res_d = RS_RETURN;
                    susp_d = 1'b0;
                    pend_d = 1'b0;
                    ret_cnt_d = '0;
                end
            end
            RS_RETURN: begin
                ret_cnt_d = ret_cnt_q + 1'b1;
                // Cap guarantees completion even if the PHY never reports idle
                if (HS_IDLE_DONE || (ret_cnt_q >= RET_CNT_W'(RET_LIMIT_CYC - 1))) begin
                    res_d = RS_IDLE;
                end
            end
            default: begin
                res_d = RS_IDLE;
            end
        endcase
        if (PORT_RESET && !port_reset_ctl_prev_q) begin
            susp_d = 1'b0;
            pend_d = 1'b0;
        end
        if (!PORT_POWER) begin
            susp_d = 1'b0;
            pend_d = 1'b0;
            res_d = RS_IDLE;
            pcd_d = 1'b0;
        end
        drive_k_d = (res_d == RS_DRIVE);
        hs_idle_d = (res_d == RS_RETURN);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            res_q <= RS_IDLE;
            susp_q <= SUSPEND_RST;
            pend_q <= 1'b0;
            occ_q <= OC_CHANGE_RST;
            pcd_q <= 1'b0;
            drive_k_q <= RESUME_DRIVE_RST;
            hs_idle_q <= 1'b0;
            ret_cnt_q <= '0;
        end else begin
            res_q <= res_d;
            susp_q <= susp_d;
            pend_q <= pend_d;
            occ_q <= occ_d;
            pcd_q <= pcd_d;
            drive_k_q <= drive_k_d;
            hs_idle_q <= hs_idle_d;
            ret_cnt_q <= ret_cnt_d;
        end
    end

    // ==========================================================
    // Read data, captured as waitrequest falls
    always_comb begin
        wait_d = 1'b1;
        rdata_d = '0;
        if ((req.read || req.write) && wait_q) begin
            wait_d = 1'b0;
        end
        if (req.read && wait_q) begin
            case (req.address)
                PORT_STATUS_OFS: begin
                    rdata_d[SUSPEND_BIT] = susp_q && PORT_POWER;
                    rdata_d[RESUME_DRIVE_BIT] = res_flag && PORT_POWER;
                    rdata_d[OC_CHANGE_BIT] = occ_q;
                    rdata_d[OC_ACTIVE_BIT] = oc_act;
                    rdata_d[PORT_ENABLED_BIT] = PORT_ENABLED;
                    rdata_d[PORT_RESET_BIT] = PORT_RESET;
                    rdata_d[PORT_POWER_BIT] = PORT_POWER;
                end
                PORT_STATE_OFS: begin
                    rdata_d[1:0] = port_state;
                    rdata_d[2] = pend_q;
                    rdata_d[3] = (res_q == RS_RETURN);
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    // Port reset travels on its own path and is never gated here
    assign BLOCK_DOWNSTREAM = susp_q;
    assign DRIVE_RESUME_K = drive_k_q;
    assign DRIVE_HS_IDLE = hs_idle_q;
    assign PORT_CHANGE_SET = pcd_q;

endmodule : rps_root_port

// ==========================================================
// Three-flop pin filter; a change counts once stages two and three agree
module rps_pin_sync
    import rps_pkg::*;
#(
    parameter logic [2:0] STAGE_RST = SYNC_RST
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic changed
);

    logic [2:0] stage_q, stage_d;
    logic level_q, level_d;

    always_comb begin
        stage_d = {stage_q[1:0], pin};
        // A one-cycle glitch is never in stages two and three at once and never counts
        level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= STAGE_RST;
            level_q <= STAGE_RST[2];
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
    // Left combinational so the change acts in the cycle the level updates
    assign changed = (level_d != level_q);

endmodule : rps_pin_sync

// ---- tb/rps_root_port_asserts.sv ----
// Checker for the root port suspend and resume block
// ========
// Port timing checks
module rps_root_port_asserts #(
    parameter int RET_LIMIT_CYC = 20
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic PORT_POWER,
    input wire logic XFER_BUSY,
    input wire logic BLOCK_DOWNSTREAM,
    input wire logic DRIVE_RESUME_K,
    input wire logic DRIVE_HS_IDLE,
    input wire logic PORT_CHANGE_SET
);
    timeunit 1ns;
    timeprecision 1ns;
    // Slack of two covers the registered outputs
    localparam int RET_MAX = RET_LIMIT_CYC + 2;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence ack_s;
        ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    sequence ret_s;
        ##[1:RET_MAX] !DRIVE_HS_IDLE;
    endsequence
    bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ack_s)
        else $error("bus answer wrong");
    blk_wait_a: assert property ($rose(BLOCK_DOWNSTREAM) |-> !$past(XFER_BUSY))
        else $error("blocked during transfer");
    pwr_clear_a: assert property (!PORT_POWER [*2] |-> !BLOCK_DOWNSTREAM && !DRIVE_RESUME_K)
        else $error("flags kept without power");
    change_pulse_a: assert property (PORT_CHANGE_SET |=> !PORT_CHANGE_SET)
        else $error("change pulse too long");
    change_drive_a: assert property (PORT_CHANGE_SET |-> ##[0:2] DRIVE_RESUME_K)
        else $error("change without resume");
    k_to_idle_a: assert property ($fell(DRIVE_RESUME_K) && PORT_POWER |-> ##[0:1] DRIVE_HS_IDLE)
        else $error("no return to idle");
    idle_unsusp_a: assert property ($rose(DRIVE_HS_IDLE) |-> ##[0:1] !BLOCK_DOWNSTREAM)
        else $error("suspend kept on return");
    ret_bound_a: assert property ($rose(DRIVE_HS_IDLE) |-> ret_s)
        else $error("return too long");
endmodule : rps_root_port_asserts

bind rps_root_port rps_root_port_asserts #(.RET_LIMIT_CYC(RET_LIMIT_CYC)) rps_root_port_asserts_i (.CLOCK(CLOCK),
    .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PORT_POWER(PORT_POWER), .XFER_BUSY(XFER_BUSY), .BLOCK_DOWNSTREAM(BLOCK_DOWNSTREAM),
    .DRIVE_RESUME_K(DRIVE_RESUME_K), .DRIVE_HS_IDLE(DRIVE_HS_IDLE), .PORT_CHANGE_SET(PORT_CHANGE_SET));

// ---- tb/rps_usb_dev.sv ----
// Model of the device on the downstream port
// ========
// Bus side of the attached device
module rps_usb_dev (
    input wire logic clock,
    input wire logic hs_idle,
    input wire logic wake,
    input wire logic oc,
    input wire logic slow,
    output logic line_k,
    output logic oc_pin,
    output logic idle_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // Outputs settle at the first edge, well inside the reset period
    always @(posedge clock) begin
        line_k <= wake;
        oc_pin <= oc;
        n <= hs_idle ? n + 1 : 0;
        // Slow mode never answers, so the host limit must end it
        idle_done <= hs_idle && !slow && n >= 4;
    end
endmodule : rps_usb_dev

// ---- tb/rps_root_port_tb.sv ----
// Self-checking testbench for the root port suspend and resume block
// ========
// Stimulus and checks
module rps_root_port_tb;
    import rps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    logic PORT_ENABLED = 1'h1;
    logic PORT_RESET = 1'h0, PORT_POWER = 1'h1, XFER_BUSY = 1'h0;
    logic wake = 1'h0, oc = 1'h0, slow = 1'h0;
    logic AVS_WAITREQUEST, BLOCK_DOWNSTREAM, DRIVE_RESUME_K, DRIVE_HS_IDLE;
    logic PORT_CHANGE_SET, LINE_K, OVERCURRENT_IN, HS_IDLE_DONE;
    int bad_count = 0, total_checks = 0, pcs_n = 0, cyc = 0, p0;
    localparam logic [31:0] BASE = (32'h1 << PORT_POWER_BIT) | (32'h1 << PORT_ENABLED_BIT);
    always #4 CLOCK = ~CLOCK;
    rps_root_port #(.RET_LIMIT_CYC(20)) rps_root_port_i (.CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PORT_ENABLED(PORT_ENABLED),
        .PORT_RESET(PORT_RESET), .PORT_POWER(PORT_POWER), .XFER_BUSY(XFER_BUSY), .HS_IDLE_DONE(HS_IDLE_DONE),
        .LINE_K(LINE_K), .OVERCURRENT_IN(OVERCURRENT_IN), .BLOCK_DOWNSTREAM(BLOCK_DOWNSTREAM),
        .DRIVE_RESUME_K(DRIVE_RESUME_K), .DRIVE_HS_IDLE(DRIVE_HS_IDLE), .PORT_CHANGE_SET(PORT_CHANGE_SET));
    rps_usb_dev rps_usb_dev_i (.clock(CLOCK), .hs_idle(DRIVE_HS_IDLE), .wake(wake), .oc(oc), .slow(slow),
        .line_k(LINE_K), .oc_pin(OVERCURRENT_IN), .idle_done(HS_IDLE_DONE));
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (PORT_CHANGE_SET === 1'h1)
            pcs_n <= pcs_n + 1;
        if (cyc == 5000) begin
            bad_count++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask : chk
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        @(posedge CLOCK);
        while (AVS_WAITREQUEST !== 1'h0)
            @(posedge CLOCK);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'h0;
        AVS_READ <= 1'h0;
        // Idle edge keeps two requests from sharing a time step
        @(posedge CLOCK);
    endtask : bus
    task st_rd();
        bus(1'h0, PORT_STATUS_OFS, 32'h0, 4'hF);
    endtask : st_rd
    task st_wr(input logic [31:0] d);
        bus(1'h1, PORT_STATUS_OFS, d, 4'hF);
    endtask : st_wr
    task susp();
        st_wr(32'h80);
        repeat (4) @(posedge CLOCK);
    endtask : susp
    task wait_ret();
        for (int i = 0; i < 40 && DRIVE_HS_IDLE !== 1'h0; i++)
            @(posedge CLOCK);
        chk("hs idle", DRIVE_HS_IDLE, 1'h0);
    endtask : wait_ret
    task t_basic();
        st_rd();
        chk("status", rd, BASE);
        bus(1'h0, 4'hC, 32'h0, 4'hF);
        chk("unmapped", rd, 32'h0);
        bus(1'h0, PORT_STATE_OFS, 32'h0, 4'hF);
        chk("state", rd[1:0], PS_ENABLED);
        PORT_ENABLED <= 1'h0;
        bus(1'h0, PORT_STATE_OFS, 32'h0, 4'hF);
        chk("disabled", rd[1:0], PS_DISABLED);
        PORT_ENABLED <= 1'h1;
    endtask : t_basic
    task t_susp();
        XFER_BUSY <= 1'h1;
        susp();
        chk("busy blk", BLOCK_DOWNSTREAM, 1'h0);
        st_rd();
        chk("busy susp", rd[SUSPEND_BIT], 1'h0);
        XFER_BUSY <= 1'h0;
        repeat (4) @(posedge CLOCK);
        chk("blk", BLOCK_DOWNSTREAM, 1'h1);
        st_wr(32'h0);
        bus(1'h0, PORT_STATE_OFS, 32'h0, 4'hF);
        chk("susp", rd[1:0], PS_SUSPENDED);
    endtask : t_susp
    task t_swres();
        p0 = pcs_n;
        st_wr(32'h40);
        repeat (10) @(posedge CLOCK);
        chk("k", DRIVE_RESUME_K, 1'h1);
        chk("no chg", pcs_n, p0);
        slow <= 1'h1;
        st_wr(32'h0);
        chk("unsusp", BLOCK_DOWNSTREAM, 1'h0);
        st_rd();
        chk("res hold", rd[RESUME_DRIVE_BIT], 1'h1);
        wait_ret();
        slow <= 1'h0;
        st_rd();
        chk("res end", rd[RESUME_DRIVE_BIT], 1'h0);
    endtask : t_swres
    task t_busres();
        susp();
        p0 = pcs_n;
        wake <= 1'h1;
        repeat (10) @(posedge CLOCK);
        wake <= 1'h0;
        chk("chg", pcs_n, p0 + 1);
        st_rd();
        chk("res set", rd[RESUME_DRIVE_BIT], 1'h1);
        st_wr(32'h0);
        wait_ret();
        st_rd();
        chk("res out", rd, BASE);
    endtask : t_busres
    task t_cut();
        susp();
        PORT_RESET <= 1'h1;
        repeat (3) @(posedge CLOCK);
        chk("port_reset_ctl", BLOCK_DOWNSTREAM, 1'h0);
        PORT_RESET <= 1'h0;
        susp();
        st_wr(32'h40);
        PORT_POWER <= 1'h0;
        repeat (3) @(posedge CLOCK);
        st_rd();
        chk("pwr", rd[7:6], 2'h0);
        PORT_POWER <= 1'h1;
        st_rd();
        chk("pwr back", rd, BASE);
    endtask : t_cut
    task t_oc();
        oc <= 1'h1;
        repeat (8) @(posedge CLOCK);
        st_rd();
        chk("oc on", rd[5:4], 2'h3);
        bus(1'h1, PORT_STATUS_OFS, 32'h20, 4'h0);
        st_wr(32'h0);
        st_rd();
        chk("oc keep", rd[5:4], 2'h3);
        st_wr(32'h20);
        st_rd();
        chk("oc clr", rd[5:4], 2'h1);
        oc <= 1'h0;
        repeat (8) @(posedge CLOCK);
        st_rd();
        chk("oc off", rd[5:4], 2'h2);
    endtask : t_oc
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'h1;
        repeat (6) @(posedge CLOCK);
        t_basic();
        t_susp();
        t_swres();
        t_busres();
        t_cut();
        t_oc();
        wrap_up();
    end
endmodule : rps_root_port_tb
